// >>> rtl/svwr_pkg.sv
package svwr_pkg;
  // clock rate and millisecond tick
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

  // debounce figures, in milliseconds
  localparam int unsigned DEB_IGNORE_MS = 1;
  localparam int unsigned DEB_ACCEPT_MS = 20;
  // filter length lies between ignore and accept limits
  localparam int unsigned DEB_FILTER_MS = 4;

  // reset active time, in milliseconds
  localparam int unsigned RST_HOLD_MS = 250;

  // watchdog periods, in milliseconds
  localparam int unsigned WD_SHORT_MS = 150;
  localparam int unsigned WD_MID_MS = 600;
  localparam int unsigned WD_LONG_MS = 1200;

  // three-state strap encoding
  typedef enum logic [1:0] {
    SVWR_STRAP_LOW = 2'h0,
    SVWR_STRAP_OPEN = 2'h1,
    SVWR_STRAP_HIGH = 2'h2
  } svwr_strap_t;

  // supervisor state, one-hot
  typedef enum logic [3:0] {
    SVWR_ST_RUN = 4'h1,
    SVWR_ST_HOLD = 4'h2,
    SVWR_ST_WDPULSE = 4'h4,
    SVWR_ST_MANUAL = 4'h8
  } svwr_state_t;

  // reset pin drive bundle
  typedef struct packed {
    logic rst_hi;
    logic rst_lo_oe_n;
  } svwr_rst_t;
endpackage

// >>> rtl/svwr_debounce.sv
module svwr_debounce #(
  parameter int unsigned FILTER_TICKS = svwr_pkg::DEB_FILTER_MS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic raw_n,
  output logic clean_n
);
  localparam int unsigned CW = $clog2(FILTER_TICKS + 1);

  initial
  begin
    if (FILTER_TICKS < svwr_pkg::DEB_IGNORE_MS + 1 || FILTER_TICKS >= svwr_pkg::DEB_ACCEPT_MS)
      $error("debounce filter length out of range");
  end

  logic [CW-1:0] cnt_q, cnt_d;
  logic clean_q, clean_d;

  // output follows input only after it differs for a whole filter span
  always_comb
  begin
    cnt_d = cnt_q;
    clean_d = clean_q;
    if (raw_n == clean_q)
      cnt_d = '0;
    else if (tick)
    begin
      if (cnt_q == CW'(FILTER_TICKS))
      begin
        clean_d = raw_n;
        cnt_d = '0;
      end
      else
        cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cnt_q <= '0;
      clean_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      clean_q <= clean_d;
    end
  end

  assign clean_n = clean_q;
endmodule

// >>> rtl/svwr_top.sv
// Notes on behaviour
// - debounce manual reset, ignore short lows
// - strap selects 150, 600 or 1200 ms
// - reset on supply, manual, watchdog, power-up
// - open-drain low output complements reset
// - margin select picks supply threshold
// - 250 ms continuous supply-ok before release
// - manual reset asserts after debounce delay
// - hold 250 ms after manual release
// - only falling kick edges service watchdog
// - missed kick gives 250 ms pulse
// - repeat pulses until a kick arrives
module svwr_top #(
  parameter int unsigned TICK_CYCLES = svwr_pkg::TICK_CYCLES,
  parameter int unsigned HOLD_MS = svwr_pkg::RST_HOLD_MS,
  parameter int unsigned WD_SHORT = svwr_pkg::WD_SHORT_MS,
  parameter int unsigned WD_MID = svwr_pkg::WD_MID_MS,
  parameter int unsigned WD_LONG = svwr_pkg::WD_LONG_MS,
  parameter int unsigned DEB_TICKS = svwr_pkg::DEB_FILTER_MS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic supply_ok_5pct,
  input wire logic supply_ok_10pct,
  input wire logic supply_margin_select,
  input wire svwr_pkg::svwr_strap_t timeout_select,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_n,
  output logic reset_out,
  output logic reset_out_n_o,
  output logic reset_out_n_oe_n
);
  localparam int unsigned TW = $clog2(TICK_CYCLES);
  localparam int unsigned MW = 11;

  initial
  begin
    if (TICK_CYCLES < 2 || HOLD_MS < 1 || HOLD_MS >= (1 << MW) || WD_LONG >= (1 << MW))
      $error("svwr_top timing parameters out of range");
    if (WD_SHORT < 1 || WD_MID < 1 || WD_LONG < 1)
      $error("svwr_top watchdog periods must be positive");
  end

  // free-running millisecond tick
  logic [TW-1:0] div_q, div_d;
  logic tick_q, tick_d;

  always_comb
  begin
    tick_d = (div_q == TW'(TICK_CYCLES - 1));
    div_d = tick_d ? '0 : div_q + TW'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // debounced manual reset
  logic mr_clean_n;

  svwr_debounce #(
    .FILTER_TICKS(DEB_TICKS)
  ) u_deb (
    .ref_clk(ref_clk),
    .srst(srst),
    .tick(tick_q),
    .raw_n(manual_reset_n),
    .clean_n(mr_clean_n)
  );

  // supply threshold and strap decode
  logic supply_ok;
  logic [MW-1:0] wd_limit;

  always_comb
  begin
    supply_ok = supply_margin_select ? supply_ok_10pct : supply_ok_5pct;
    case (timeout_select)
      svwr_pkg::SVWR_STRAP_LOW: wd_limit = MW'(WD_SHORT);
      svwr_pkg::SVWR_STRAP_HIGH: wd_limit = MW'(WD_LONG);
      default: wd_limit = MW'(WD_MID);
    endcase
  end

  // kick edge detect
  logic kick_q, kick_d;
  logic kick_fall;

  always_comb
  begin
    kick_d = watchdog_kick_n;
    kick_fall = kick_q & ~watchdog_kick_n;
  end

  // supervisor state
  svwr_pkg::svwr_state_t st_q, st_d;
  logic [MW-1:0] hold_q, hold_d;
  logic [MW-1:0] wd_q, wd_d;
  svwr_pkg::svwr_rst_t pin_q, pin_d;

  always_comb
  begin
    st_d = st_q;
    hold_d = hold_q;
    wd_d = wd_q;
    if (!supply_ok)
    begin
      // any dropout restarts the hold interval
      st_d = svwr_pkg::SVWR_ST_HOLD;
      hold_d = '0;
      wd_d = '0;
    end
    else if (!mr_clean_n)
    begin
      st_d = svwr_pkg::SVWR_ST_MANUAL;
      hold_d = '0;
      wd_d = '0;
    end
    else
    begin
      case (st_q)
        svwr_pkg::SVWR_ST_RUN:
        begin
          if (kick_fall)
            wd_d = '0;
          else if (tick_q)
          begin
            if (wd_q == wd_limit - MW'(1))
            begin
              st_d = svwr_pkg::SVWR_ST_WDPULSE;
              hold_d = '0;
              wd_d = '0;
            end
            else
              wd_d = wd_q + MW'(1);
          end
        end
        svwr_pkg::SVWR_ST_HOLD, svwr_pkg::SVWR_ST_MANUAL, svwr_pkg::SVWR_ST_WDPULSE:
        begin
          wd_d = '0;
          if (tick_q)
          begin
            if (hold_q == MW'(HOLD_MS - 1))
            begin
              st_d = svwr_pkg::SVWR_ST_RUN;
              hold_d = '0;
              wd_d = '0;
            end
            else
              hold_d = hold_q + MW'(1);
          end
        end
        default:
        begin
          st_d = svwr_pkg::SVWR_ST_HOLD;
          hold_d = '0;
          wd_d = '0;
        end
      endcase
    end
    pin_d.rst_hi = (st_d != svwr_pkg::SVWR_ST_RUN);
    pin_d.rst_lo_oe_n = ~pin_d.rst_hi;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      // power-up starts in the hold interval
      st_q <= svwr_pkg::SVWR_ST_HOLD;
      hold_q <= '0;
      wd_q <= '0;
      kick_q <= 1'b1;
      pin_q <= '{rst_hi: 1'b1, rst_lo_oe_n: 1'b0};
    end
    else
    begin
      st_q <= st_d;
      hold_q <= hold_d;
      wd_q <= wd_d;
      kick_q <= kick_d;
      pin_q <= pin_d;
    end
  end

  assign reset_out = pin_q.rst_hi;
  assign reset_out_n_o = 1'b0;
  assign reset_out_n_oe_n = pin_q.rst_lo_oe_n;

  // checker helpers: ticks of unbroken supply-ok, raw manual low, debounced manual high
  logic [MW-1:0] sup_ms_q, sup_ms_d;
  logic [MW-1:0] mr_low_q, mr_low_d;
  logic [MW-1:0] mr_high_q, mr_high_d;

  always_comb
  begin
    sup_ms_d = sup_ms_q;
    mr_low_d = mr_low_q;
    mr_high_d = mr_high_q;
    if (!supply_ok)
      sup_ms_d = '0;
    else if (tick_q && sup_ms_q != '1)
      sup_ms_d = sup_ms_q + MW'(1);
    if (manual_reset_n)
      mr_low_d = '0;
    else if (tick_q && mr_low_q != '1)
      mr_low_d = mr_low_q + MW'(1);
    if (!mr_clean_n)
      mr_high_d = '0;
    else if (tick_q && mr_high_q != '1)
      mr_high_d = mr_high_q + MW'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sup_ms_q <= '0;
      mr_low_q <= '0;
      mr_high_q <= '0;
    end
    else
    begin
      sup_ms_q <= sup_ms_d;
      mr_low_q <= mr_low_d;
      mr_high_q <= mr_high_d;
    end
  end

  // a watchdog pulse only starts from run after the full period
  a_wd_pulse_start: assert property (@(posedge ref_clk) disable iff (srst)
    (st_q == svwr_pkg::SVWR_ST_WDPULSE) && ($past(st_q) == svwr_pkg::SVWR_ST_RUN)
    |-> $past(wd_q) == wd_limit - MW'(1)) else $error("early watchdog pulse");
  a_wd_repeat: assert property (@(posedge ref_clk) disable iff (srst)
    (st_q == svwr_pkg::SVWR_ST_RUN) && tick_q && !kick_fall && supply_ok && mr_clean_n
    && (wd_q == wd_limit - MW'(1)) |=> st_q == svwr_pkg::SVWR_ST_WDPULSE)
    else $error("missed watchdog pulse");
  a_kick_clears: assert property (@(posedge ref_clk) disable iff (srst)
    (st_q == svwr_pkg::SVWR_ST_RUN) && kick_fall && supply_ok && mr_clean_n
    |=> wd_q == '0) else $error("kick did not restart watchdog");
  a_rise_no_kick: assert property (@(posedge ref_clk) disable iff (srst)
    (st_q == svwr_pkg::SVWR_ST_RUN) && !kick_q && watchdog_kick_n && !tick_q
    && supply_ok && mr_clean_n
    |=> wd_q == $past(wd_q)) else $error("rising edge serviced watchdog");
  a_supply_reset: assert property (@(posedge ref_clk) disable iff (srst)
    !supply_ok |=> reset_out && !reset_out_n_oe_n) else $error("no reset on low supply");
  a_pins_compl: assert property (@(posedge ref_clk) disable iff (srst)
    reset_out == !reset_out_n_oe_n) else $error("reset pins disagree");
  a_hold_release: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(reset_out) |-> $past(hold_q) == MW'(HOLD_MS - 1) && $past(tick_q))
    else $error("release before hold time");
  a_manual_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !mr_clean_n |=> st_q == svwr_pkg::SVWR_ST_MANUAL || st_q == svwr_pkg::SVWR_ST_HOLD)
    else $error("manual reset not held");
  a_wd_frozen: assert property (@(posedge ref_clk) disable iff (srst)
    (!supply_ok || !mr_clean_n) |=> wd_q == '0) else $error("watchdog ran in reset");
  a_margin_sel: assert property (@(posedge ref_clk) disable iff (srst)
    supply_margin_select && !supply_ok_10pct |=> st_q == svwr_pkg::SVWR_ST_HOLD)
    else $error("margin select ignored");
  a_pin_state: assert property (@(posedge ref_clk) disable iff (srst)
    reset_out == (st_q != svwr_pkg::SVWR_ST_RUN))
    else $error("reset pin does not follow state");
  a_tick_single: assert property (@(posedge ref_clk) disable iff (srst)
    tick_q |-> div_q == '0)
    else $error("tick out of step with divider");
  a_wd_bound: assert property (@(posedge ref_clk) disable iff (srst)
    (st_q == svwr_pkg::SVWR_ST_RUN) |-> wd_q < wd_limit)
    else $error("watchdog count passed its period");
  a_idle_wd: assert property (@(posedge ref_clk) disable iff (srst)
    (st_q != svwr_pkg::SVWR_ST_RUN) |=> wd_q == '0)
    else $error("watchdog counted during reset");
  a_hold_restart: assert property (@(posedge ref_clk) disable iff (srst)
    !supply_ok |=> hold_q == '0)
    else $error("dropout did not restart hold");
  a_supply_stable: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(reset_out) |-> sup_ms_q >= MW'(HOLD_MS))
    else $error("release without stable supply");
  // manual path: raw low, debounce, entry, release
  a_manual_delay: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(mr_clean_n) |-> $past(manual_reset_n) == 1'b0)
    else $error("manual reset without low input");
  a_deb_ignore: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(mr_clean_n) |-> mr_low_q >= MW'(DEB_TICKS + 1))
    else $error("short manual low accepted");
  a_deb_accept: assert property (@(posedge ref_clk) disable iff (srst)
    mr_low_q >= MW'(DEB_TICKS + 1) |-> !mr_clean_n)
    else $error("long manual low not accepted");
  a_manual_enter: assert property (@(posedge ref_clk) disable iff (srst)
    !mr_clean_n && supply_ok |=> st_q == svwr_pkg::SVWR_ST_MANUAL)
    else $error("manual reset not entered");
  a_manual_release: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(mr_clean_n) |-> reset_out)
    else $error("reset gone at manual release");
  a_mr_hold_time: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(reset_out) |-> mr_high_q >= MW'(HOLD_MS))
    else $error("release too soon after manual");

  c_wd_pulse: cover property (@(posedge ref_clk) disable iff (srst)
    st_q == svwr_pkg::SVWR_ST_WDPULSE);
  c_manual: cover property (@(posedge ref_clk) disable iff (srst)
    st_q == svwr_pkg::SVWR_ST_MANUAL);
  c_release: cover property (@(posedge ref_clk) disable iff (srst) $fell(reset_out));
  c_supply_drop: cover property (@(posedge ref_clk) disable iff (srst)
    $fell(supply_ok));
  c_kick: cover property (@(posedge ref_clk) disable iff (srst)
    kick_fall && st_q == svwr_pkg::SVWR_ST_RUN);
endmodule

// >>> verif/svwr_cpu_model.sv
module svwr_cpu_model (
  input wire logic ref_clk,
  input wire logic reset_out,
  input wire logic run,
  input wire logic idle_lvl,
  output logic kick_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial kick_n = 1'b1;
  // foreground sets the line high, background sets it low, 20 cycles apart
  always @(posedge ref_clk)
  begin
    cnt <= (cnt == 19) ? 0 : cnt + 1;
    if (!run)
      kick_n <= #1 idle_lvl;
    else if (!reset_out && cnt == 19)
      kick_n <= #1 ~kick_n;
  end
endmodule

// >>> verif/tb_svwr_top.sv
module tb_svwr_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 10;
  localparam int H = 5;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ok5 = 1'b1;
  logic ok10 = 1'b1;
  logic msel = 1'b0;
  logic mr_n = 1'b1;
  logic run = 1'b1;
  logic idle = 1'b1;
  logic kick_n, rst_o, rst_n_o, rst_n_oe_n;
  svwr_pkg::svwr_strap_t tsel = svwr_pkg::SVWR_STRAP_LOW;
  svwr_pkg::svwr_strap_t straps [4] = '{svwr_pkg::SVWR_STRAP_LOW, svwr_pkg::SVWR_STRAP_OPEN,
    svwr_pkg::SVWR_STRAP_HIGH, svwr_pkg::svwr_strap_t'(2'h3)};
  int pers [4] = '{8, 12, 20, 12};
  int n_fail = 0;
  int n_compared = 0;
  int n;
  always #5 ref_clk = ~ref_clk;
  svwr_top #(.TICK_CYCLES(T), .HOLD_MS(H), .WD_SHORT(8), .WD_MID(12), .WD_LONG(20),
    .DEB_TICKS(2)) u_svwr_top (.ref_clk(ref_clk), .srst(srst), .supply_ok_5pct(ok5),
    .supply_ok_10pct(ok10), .supply_margin_select(msel), .timeout_select(tsel),
    .manual_reset_n(mr_n), .watchdog_kick_n(kick_n), .reset_out(rst_o),
    .reset_out_n_o(rst_n_o), .reset_out_n_oe_n(rst_n_oe_n));
  svwr_cpu_model u_svwr_cpu_model (.ref_clk(ref_clk), .reset_out(rst_o), .run(run),
    .idle_lvl(idle), .kick_n(kick_n));
  task results();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task check(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // waits for a reset level, counting cycles, and checks the open-drain pair
  task wait_lvl(input logic lvl, input int max);
    n = 0;
    while (rst_o !== lvl && n < max)
    begin
      cyc(1);
      n++;
    end
    check(rst_n_o, 1'h0);
    check(rst_n_oe_n, ~rst_o);
  endtask
  task t_powerup();
    check(rst_o, 1'h1);
    cyc(3 * T);
    check(rst_o, 1'h1);
    wait_lvl(1'h0, 4 * T);
    check(rst_o, 1'h0);
  endtask
  task t_supply();
    ok5 = 1'b0;
    cyc(2);
    check(rst_o, 1'h1);
    ok5 = 1'b1;
    cyc(3 * T);
    ok5 = 1'b0;
    cyc(1);
    ok5 = 1'b1;
    cyc(4 * T);
    check(rst_o, 1'h1);
    wait_lvl(1'h0, 4 * T);
    check(rst_o, 1'h0);
    msel = 1'b1;
    ok5 = 1'b0;
    cyc(3 * T);
    check(rst_o, 1'h0);
    ok10 = 1'b0;
    cyc(2);
    check(rst_o, 1'h1);
    ok5 = 1'b1;
    ok10 = 1'b1;
    msel = 1'b0;
    wait_lvl(1'h0, 8 * T);
    check(rst_o, 1'h0);
  endtask
  task t_manual();
    mr_n = 1'b0;
    cyc(5);
    mr_n = 1'b1;
    cyc(6 * T);
    check(rst_o, 1'h0);
    mr_n = 1'b0;
    cyc(1);
    check(rst_o, 1'h0);
    wait_lvl(1'h1, 6 * T);
    check(rst_o, 1'h1);
    cyc(10 * T);
    mr_n = 1'b1;
    cyc(4 * T);
    check(rst_o, 1'h1);
    wait_lvl(1'h0, 10 * T);
    check(rst_o, 1'h0);
  endtask
  // stops the kicks with a low level, then a lone rising edge that must not count
  task t_watchdog(input svwr_pkg::svwr_strap_t s, input int p);
    tsel = s;
    run = 1'b1;
    cyc(3 * p * T);
    check(rst_o, 1'h0);
    idle = 1'b0;
    run = 1'b0;
    cyc(2 * T);
    idle = 1'b1;
    wait_lvl(1'h1, (p + 2) * T);
    check(n >= (p - 3) * T - 20 && n <= p * T - 18, 1'h1);
    wait_lvl(1'h0, (H + 2) * T);
    check(n >= (H - 1) * T && n <= (H + 1) * T, 1'h1);
    wait_lvl(1'h1, (p + 2) * T);
    check(n >= (p - 1) * T && n <= p * T + 3, 1'h1);
    run = 1'b1;
    wait_lvl(1'h0, (H + 2) * T);
    cyc(2 * p * T);
    check(rst_o, 1'h0);
  endtask
  initial
  begin
    cyc(16);
    srst = 1'b0;
    t_powerup();
    t_supply();
    t_manual();
    for (int i = 0; i < 4; i++)
      t_watchdog(straps[i], pers[i]);
    results();
  end
  initial
  begin
    #200000;
    n_fail++;
    results();
  end
endmodule
